// ===== rtl/rts_pkg.sv
// Shared constants for the tag serial port and its external master.
package rts_pkg;
    localparam int          CLK_MHZ      = 250;
    localparam int          T_PU_US      = 1000;
    localparam int          PU_CYCLES    = T_PU_US * CLK_MHZ;
    localparam int          SCK_PERIOD_NS = 160;
    localparam int          CLK_PERIOD_NS = 4;
    localparam int          SCK_HALF     = SCK_PERIOD_NS / CLK_PERIOD_NS / 2;
    localparam int          SETTLE_CYC   = 8;
    localparam int          USER_BYTES   = 3424;
    localparam int          MEM_AW       = 12;
    localparam int          ADDR_BITS    = 16;
    localparam int          FRAME_BITS   = 32;
    localparam logic [7:0]  OP_WRITE     = 8'h02;
    localparam logic [7:0]  OP_READ      = 8'h03;
    localparam logic [7:0]  OP_STATUS    = 8'h05;
    localparam logic [7:0]  RD_FILL      = 8'h00;
    localparam logic [5:0]  SYNC_RST     = 6'h00;

    typedef enum logic [4:0] {
        RTS_IDLE = 5'b00001,
        RTS_CMD  = 5'b00010,
        RTS_ADDR = 5'b00100,
        RTS_DATA = 5'b01000,
        RTS_SKIP = 5'b10000
    } rts_dev_e;

    typedef enum logic [4:0] {
        RTS_OFF   = 5'b00001,
        RTS_CHECK = 5'b00010,
        RTS_PWRUP = 5'b00100,
        RTS_READY = 5'b01000,
        RTS_XFER  = 5'b10000
    } rts_host_e;
endpackage

// ===== rtl/rts_if.sv
// Serial link between the tag port and its external master.
`timescale 1ns/10ps
interface rts_if;
    logic supply_on;
    logic mode_sel;
    logic chip_select_n;
    logic write_protect_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    logic busy;
    logic so_wire;

    // A released data line reads low here; the bench may model a pull.
    assign so_wire = so_oe & so;

    modport tag (
        input  supply_on,
        input  mode_sel,
        input  chip_select_n,
        input  write_protect_n,
        input  sck,
        input  si,
        output so,
        output so_oe,
        output busy
    );

    modport master (
        output supply_on,
        output mode_sel,
        output chip_select_n,
        output write_protect_n,
        output sck,
        output si,
        input  so_wire,
        input  busy
    );
endinterface

// ===== rtl/rts_tag_port.sv
// Tag end: serial slave port onto the user region of the tag memory.
`timescale 1ns/10ps
module rts_tag_port (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    rts_if.tag        link,
    input  wire logic rf_active,
    output logic      serial_mode,
    output logic      wr_done
);
    localparam int MEM_AW_L = rts_pkg::MEM_AW;

    logic [5:0]           s1_q;
    logic [5:0]           s2_q;
    logic                 sck_prev_q;
    logic                 busy_q;
    logic                 so_q;
    logic                 so_oe_q;
    logic                 serial_mode_q;
    logic                 wr_done_q;
    logic                 wr_pend_q;
    logic [MEM_AW_L-1:0]  wr_addr_q;
    logic [7:0]           wr_data_q;
    rts_pkg::rts_dev_e    st_q;
    logic [3:0]           cnt_q;
    logic [6:0]           sh_q;
    logic                 is_rd_q;
    logic                 is_wr_q;
    logic                 is_stat_q;
    logic [15:0]          addr_q;
    logic [7:0]           out_q;
    logic [7:0]           mem [0:rts_pkg::USER_BYTES-1];

    logic        sup;
    logic        mode;
    logic        cs_n;
    logic        wp_n;
    logic        sck;
    logic        si;
    logic        rise;
    logic        fall;
    logic        active;
    logic [15:0] rd_addr;
    logic [7:0]  rd_byte;
    logic [7:0]  stat_byte;
    logic [7:0]  new_byte;

    function automatic logic in_user(input logic [15:0] a);
        in_user = (32'(a) < rts_pkg::USER_BYTES);
    endfunction

    // Every link input is a pin from another domain: two flops first.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= rts_pkg::SYNC_RST;
            s2_q <= rts_pkg::SYNC_RST;
        end else begin
            s1_q <= {link.supply_on, link.mode_sel, link.chip_select_n,
                     link.write_protect_n, link.sck, link.si};
            s2_q <= s1_q;
        end
    end

    assign sup  = s2_q[5];
    assign mode = s2_q[4];
    assign cs_n = s2_q[3];
    assign wp_n = s2_q[2];
    assign sck  = s2_q[1];
    assign si   = s2_q[0];

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= sck;
        end
    end

    // Only edges seen while selected count, so an idle-high clock at
    // select time (mode three) produces no false first edge.
    assign rise = sck & ~sck_prev_q;
    assign fall = ~sck & sck_prev_q;

    // RF activity while the supply is present shows as busy.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= sup & rf_active;
        end
    end

    // Selected, in serial mode and not yielding to the RF side.
    assign active = sup & mode & ~cs_n &
                    ~busy_q;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            serial_mode_q <= 1'b0;
        end else begin
            serial_mode_q <= sup & mode & ~busy_q;
        end
    end

    assign new_byte  = {sh_q, si};
    assign rd_addr   = (st_q == rts_pkg::RTS_ADDR) ? {addr_q[14:0], si}
                                                   : addr_q + 16'h0001;
    assign rd_byte   = in_user(rd_addr) ? mem[rd_addr[MEM_AW_L-1:0]]
                                        : rts_pkg::RD_FILL;
    assign stat_byte = {6'h00, ~wp_n, wr_pend_q};

    // Command, address and data are taken on rising clock edges.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q      <= rts_pkg::RTS_IDLE;
            cnt_q     <= 4'h0;
            sh_q      <= 7'h00;
            is_rd_q   <= 1'b0;
            is_wr_q   <= 1'b0;
            is_stat_q <= 1'b0;
            addr_q    <= 16'h0000;
            out_q     <= 8'h00;
        end else if (!active) begin
            st_q  <= rts_pkg::RTS_IDLE;
            cnt_q <= 4'h0;
        end else if (rise) begin
            sh_q  <= new_byte[6:0];
            cnt_q <= cnt_q + 4'h1;
            case (st_q)
                rts_pkg::RTS_IDLE, rts_pkg::RTS_CMD: begin
                    st_q <= rts_pkg::RTS_CMD;
                    if (cnt_q == 4'h7) begin
                        cnt_q     <= 4'h0;
                        is_rd_q   <= (new_byte == rts_pkg::OP_READ);
                        is_wr_q   <= (new_byte == rts_pkg::OP_WRITE);
                        is_stat_q <= (new_byte == rts_pkg::OP_STATUS);
                        if (new_byte == rts_pkg::OP_STATUS) begin
                            out_q <= stat_byte;
                            st_q  <= rts_pkg::RTS_DATA;
                        end else if (new_byte == rts_pkg::OP_READ ||
                                     new_byte == rts_pkg::OP_WRITE) begin
                            st_q <= rts_pkg::RTS_ADDR;
                        end else begin
                            st_q <= rts_pkg::RTS_SKIP;
                        end
                    end
                end
                rts_pkg::RTS_ADDR: begin
                    addr_q <= {addr_q[14:0], si};
                    if (cnt_q == 4'hf) begin
                        cnt_q <= 4'h0;
                        out_q <= rd_byte;
                        st_q  <= rts_pkg::RTS_DATA;
                    end
                end
                rts_pkg::RTS_DATA: begin
                    if (cnt_q == 4'h7) begin
                        cnt_q <= 4'h0;
                        if (is_stat_q) begin
                            out_q <= stat_byte;
                        end else begin
                            addr_q <= addr_q + 16'h0001;
                            out_q  <= rd_byte;
                        end
                    end
                end
                rts_pkg::RTS_SKIP: begin
                    cnt_q <= 4'h0;
                end
                default: begin
                    st_q <= rts_pkg::RTS_IDLE;
                end
            endcase
        end else if (fall && st_q == rts_pkg::RTS_DATA &&
                     (is_rd_q || is_stat_q)) begin
            out_q <= {out_q[6:0], 1'b0};
        end
    end

    // Output bits move only on falling edges; released when idle.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            so_q    <= 1'b0;
            so_oe_q <= 1'b0;
        end else if (!active) begin
            so_q    <= 1'b0;
            so_oe_q <= 1'b0;
        end else if (fall && st_q == rts_pkg::RTS_DATA &&
                     (is_rd_q || is_stat_q)) begin
            so_q    <= out_q[7];
            so_oe_q <= 1'b1;
        end
    end

    // A completed byte is latched here and written even if the master
    // deselects at once, so a write is never cut in half.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            wr_data_q <= 8'h00;
        end else if (active && rise && st_q == rts_pkg::RTS_DATA &&
                     is_wr_q && cnt_q == 4'h7) begin
            wr_pend_q <= wp_n & in_user(addr_q);
            wr_addr_q <= addr_q[MEM_AW_L-1:0];
            wr_data_q <= new_byte;
        end else begin
            wr_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (wr_pend_q) begin
            mem[wr_addr_q] <= wr_data_q;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_done_q <= 1'b0;
        end else begin
            wr_done_q <= wr_pend_q;
        end
    end

    // The port never drives clock or select; it only answers.
    assign link.so      = so_q;
    assign link.so_oe   = so_oe_q;
    assign link.busy    = busy_q;
    assign serial_mode  = serial_mode_q;
    assign wr_done      = wr_done_q;
endmodule

// ===== rtl/rts_master.sv
// Master end: powers the tag, runs the select sequence, moves bytes.
`timescale 1ns/10ps
module rts_master #(
    parameter int PU_CYCLES = rts_pkg::PU_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    rts_if.master            link,
    input  wire logic        power_en,
    input  wire logic        protect,
    input  wire logic        req,
    input  wire logic        req_write,
    input  wire logic [15:0] req_addr,
    input  wire logic [7:0]  req_wdata,
    output logic             ready,
    output logic             done,
    output logic             fail,
    output logic [7:0]       rdata
);
    logic [1:0]         bs_q;
    logic [1:0]         ss_q;
    rts_pkg::rts_host_e st_q;
    logic [17:0]        tmr_q;
    logic [5:0]         hc_q;
    logic [4:0]         bit_q;
    logic [31:0]        frame_q;
    logic [7:0]         rsh_q;
    logic               sup_q;
    logic               mode_q;
    logic               cs_n_q;
    logic               wp_n_q;
    logic               sck_q;
    logic               si_q;
    logic               ready_q;
    logic               done_q;
    logic               fail_q;
    logic [7:0]         rdata_q;
    logic               busy;
    logic               tick;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bs_q <= 2'h0;
            ss_q <= 2'h0;
        end else begin
            bs_q <= {bs_q[0], link.busy};
            ss_q <= {ss_q[0], link.so_wire};
        end
    end

    assign busy = bs_q[1];
    assign tick = (hc_q == 6'(rts_pkg::SCK_HALF - 1));

    // Half-period enable for the serial clock divider.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hc_q <= 6'h00;
        end else if (st_q != rts_pkg::RTS_XFER || tick) begin
            hc_q <= 6'h00;
        end else begin
            hc_q <= hc_q + 6'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q    <= rts_pkg::RTS_OFF;
            tmr_q   <= 18'h00000;
            bit_q   <= 5'h00;
            frame_q <= 32'h00000000;
            rsh_q   <= 8'h00;
            sup_q   <= 1'b0;
            mode_q  <= 1'b0;
            cs_n_q  <= 1'b0;
            wp_n_q  <= 1'b0;
            sck_q   <= 1'b0;
            si_q    <= 1'b0;
            ready_q <= 1'b0;
            done_q  <= 1'b0;
            fail_q  <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            done_q <= 1'b0;
            fail_q <= 1'b0;
            if (st_q != rts_pkg::RTS_OFF && busy) begin
                // RF owns the tag: drop supply and park every line low.
                fail_q  <= (st_q == rts_pkg::RTS_XFER);
                done_q  <= (st_q == rts_pkg::RTS_XFER);
                st_q    <= rts_pkg::RTS_OFF;
                tmr_q   <= 18'h00000;
                sup_q   <= 1'b0;
                mode_q  <= 1'b0;
                cs_n_q  <= 1'b0;
                wp_n_q  <= 1'b0;
                sck_q   <= 1'b0;
                si_q    <= 1'b0;
                ready_q <= 1'b0;
            end else begin
                case (st_q)
                    rts_pkg::RTS_OFF: begin
                        tmr_q <= tmr_q + 18'h00001;
                        if (power_en &&
                            tmr_q >= 18'(rts_pkg::SETTLE_CYC)) begin
                            sup_q <= 1'b1;
                            tmr_q <= 18'h00000;
                            st_q  <= rts_pkg::RTS_CHECK;
                        end
                    end
                    rts_pkg::RTS_CHECK: begin
                        tmr_q <= tmr_q + 18'h00001;
                        if (tmr_q == 18'(rts_pkg::SETTLE_CYC)) begin
                            mode_q <= 1'b1;
                            cs_n_q <= 1'b1;
                            wp_n_q <= ~protect;
                            tmr_q  <= 18'h00000;
                            st_q   <= rts_pkg::RTS_PWRUP;
                        end
                    end
                    rts_pkg::RTS_PWRUP: begin
                        tmr_q <= tmr_q + 18'h00001;
                        if (tmr_q == 18'(PU_CYCLES - 1)) begin
                            cs_n_q  <= 1'b1;
                            ready_q <= 1'b1;
                            st_q    <= rts_pkg::RTS_READY;
                        end
                    end
                    rts_pkg::RTS_READY: begin
                        wp_n_q <= ~protect;
                        if (!power_en) begin
                            sup_q   <= 1'b0;
                            mode_q  <= 1'b0;
                            cs_n_q  <= 1'b0;
                            wp_n_q  <= 1'b0;
                            ready_q <= 1'b0;
                            tmr_q   <= 18'h00000;
                            st_q    <= rts_pkg::RTS_OFF;
                        end else if (req) begin
                            frame_q <= {req_write ? rts_pkg::OP_WRITE
                                                  : rts_pkg::OP_READ,
                                        req_addr, req_wdata};
                            si_q    <= req_write ? rts_pkg::OP_WRITE[7]
                                                 : rts_pkg::OP_READ[7];
                            cs_n_q  <= 1'b0;
                            sck_q   <= 1'b0;
                            bit_q   <= 5'h00;
                            ready_q <= 1'b0;
                            st_q    <= rts_pkg::RTS_XFER;
                        end
                    end
                    rts_pkg::RTS_XFER: begin
                        if (tick && !sck_q) begin
                            sck_q <= 1'b1;
                            rsh_q <= {rsh_q[6:0], ss_q[1]};
                        end else if (tick) begin
                            sck_q <= 1'b0;
                            bit_q <= bit_q + 5'h01;
                            frame_q <= {frame_q[30:0], 1'b0};
                            si_q  <= frame_q[30];
                            if (bit_q == 5'(rts_pkg::FRAME_BITS - 1)) begin
                                cs_n_q  <= 1'b1;
                                si_q    <= 1'b0;
                                rdata_q <= rsh_q;
                                done_q  <= 1'b1;
                                ready_q <= 1'b1;
                                st_q    <= rts_pkg::RTS_READY;
                            end
                        end
                    end
                    default: begin
                        st_q <= rts_pkg::RTS_OFF;
                    end
                endcase
            end
        end
    end

    assign link.supply_on       = sup_q;
    assign link.mode_sel        = mode_q;
    assign link.chip_select_n   = cs_n_q;
    assign link.write_protect_n = wp_n_q;
    assign link.sck             = sck_q;
    assign link.si              = si_q;
    assign ready                = ready_q;
    assign done                 = done_q;
    assign fail                 = fail_q;
    assign rdata                = rdata_q;
endmodule

// ===== sim/rts_asserts.sv
// Checker on the serial link between the tag port and its master.
`timescale 1ns/10ps
module rts_asserts (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic supply_on,
    input wire logic mode_sel,
    input wire logic chip_select_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe,
    input wire logic busy
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // Bounds leave room for the two-flop synchronisers on each end.
    AST_BUSY_SUPPLY: assert property (!supply_on [*4] |-> !busy)
        else $error("busy high without supply");
    AST_BUSY_QUIET: assert property (busy [*4] |-> !so_oe)
        else $error("data driven while busy");
    AST_MODE_BUSY: assert property ($rose(mode_sel) |-> !busy)
        else $error("serial mode entered while busy");
    AST_MODE_SEL: assert property (
        $rose(mode_sel) |-> supply_on && chip_select_n)
        else $error("mode raised without supply and select high");
    AST_DESEL_REL: assert property (chip_select_n [*5] |-> !so_oe)
        else $error("data driven while deselected");
    AST_MODE_LOW: assert property (!mode_sel [*5] |-> !so_oe)
        else $error("data driven with mode low");
    AST_SCK_SEL: assert property ($rose(sck) |-> !chip_select_n)
        else $error("clock edge while deselected");
    AST_SI_RISE: assert property ($rose(sck) |-> $stable(si))
        else $error("data in moved at rising clock");
    AST_SO_FALL: assert property (
        so_oe && $past(so_oe) && $changed(so) |-> !$past(sck, 2))
        else $error("data out moved away from falling clock");
    AST_IDLE_LOW: assert property ($changed(chip_select_n) |-> !sck)
        else $error("clock not idle low at select change");
    AST_BUSY_DROP: assert property (
        busy |-> ##[1:5] (!supply_on && !mode_sel && !sck && !si))
        else $error("master kept lines up while busy");

    COV_BUSY: cover property ($rose(busy));
    COV_READ: cover property ($rose(so_oe));
    COV_POWER: cover property ($rose(mode_sel));
    COV_DROP: cover property ($fell(supply_on));
endmodule

// ===== sim/rfid_tag_spi_slave_port_bench.sv
// Bench joining the tag port and its master across the serial link.
`timescale 1ns/10ps
module rfid_tag_spi_slave_port_bench;
    localparam int PU = 50;
    logic        ref_clk;
    logic        reset_n;
    logic        rf_active;
    logic        power_en;
    logic        protect;
    logic        req;
    logic        req_write;
    logic [15:0] req_addr;
    logic [7:0]  req_wdata;
    logic [7:0]  rdata;
    logic        serial_mode;
    logic        wr_done;
    logic        ready;
    logic        done;
    logic        fail;
    int          n_fail;
    int          compares;
    int          n_wr;
    int          wr_seen;
    int          cyc;
    logic [15:0] addr_t [3];
    logic [7:0]  data_t [3];

    rts_if lnk ();

    rts_tag_port u_rts_tag_port (
        .ref_clk     (ref_clk),
        .reset_n     (reset_n),
        .link        (lnk.tag),
        .rf_active   (rf_active),
        .serial_mode (serial_mode),
        .wr_done     (wr_done)
    );

    rts_master #(.PU_CYCLES(PU)) u_rts_master (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .link      (lnk.master),
        .power_en  (power_en),
        .protect   (protect),
        .req       (req),
        .req_write (req_write),
        .req_addr  (req_addr),
        .req_wdata (req_wdata),
        .ready     (ready),
        .done      (done),
        .fail      (fail),
        .rdata     (rdata)
    );

    rts_asserts u_rts_asserts (
        .ref_clk       (ref_clk),
        .reset_n       (reset_n),
        .supply_on     (lnk.supply_on),
        .mode_sel      (lnk.mode_sel),
        .chip_select_n (lnk.chip_select_n),
        .sck           (lnk.sck),
        .si            (lnk.si),
        .so            (lnk.so),
        .so_oe         (lnk.so_oe),
        .busy          (lnk.busy)
    );

    always #2 ref_clk = ~ref_clk;

    task automatic conclude;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Each run is under eleven frames of 1280 clock cycles; the ceiling is about three times that.
    always @(posedge ref_clk) begin
        cyc++;
        if (wr_done === 1'b1)
            n_wr++;
        if (cyc == 40000) begin
            n_fail++;
            conclude();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string msg);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic wait_ready;
        for (int i = 0; i < 2000 && ready !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        chk(8'(ready), 8'h01, "ready");
    endtask

    task automatic wait_done;
        for (int i = 0; i < 2000 && done !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        chk(8'(done), 8'h01, "done");
    endtask

    task automatic xfer(input logic w, input logic [15:0] a,
                        input logic [7:0] d);
        int w0;
        w0 = n_wr;
        @(posedge ref_clk);
        req       <= 1'b1;
        req_write <= w;
        req_addr  <= a;
        req_wdata <= d;
        @(posedge ref_clk);
        req <= 1'b0;
        #1;
        wait_done();
        wr_seen = n_wr - w0;
    endtask

    initial begin
        ref_clk   = 1'b0;
        reset_n   = 1'b0;
        rf_active = 1'b0;
        power_en  = 1'b0;
        protect   = 1'b0;
        req       = 1'b0;
        req_write = 1'b0;
        req_addr  = 16'h0000;
        req_wdata = 8'h00;
        n_fail    = 0;
        compares  = 0;
        n_wr      = 0;
        cyc       = 0;
        addr_t    = '{16'h0000, 16'h0d5f, 16'h0d60};
        data_t    = '{8'h3c, 8'hc3, 8'h99};
        repeat (2) @(posedge ref_clk);
        reset_n  <= 1'b1;
        power_en <= 1'b1;
        #1;
        wait_ready();
        chk(8'(serial_mode), 8'h01, "serial mode");
        $display("test power done");
        // The last entry lies just past the user region.
        for (int k = 0; k < 3; k++) begin
            xfer(1'b1, addr_t[k], data_t[k]);
            chk(8'(wr_seen), 8'(k < 2), "write count");
            xfer(1'b0, addr_t[k], 8'h00);
            chk(rdata, (k < 2) ? data_t[k] : 8'h00, "read back");
        end
        $display("test region done");
        @(posedge ref_clk);
        protect <= 1'b1;
        xfer(1'b1, 16'h0000, 8'hff);
        chk(8'(wr_seen), 8'h00, "protected write");
        @(posedge ref_clk);
        protect <= 1'b0;
        xfer(1'b0, 16'h0000, 8'h00);
        chk(rdata, 8'h3c, "kept data");
        $display("test protect done");
        @(posedge ref_clk);
        req       <= 1'b1;
        req_write <= 1'b1;
        req_addr  <= 16'h0000;
        req_wdata <= 8'h55;
        @(posedge ref_clk);
        req <= 1'b0;
        // Land the RF burst in mid-frame, during the address bits.
        repeat (600) @(posedge ref_clk);
        rf_active <= 1'b1;
        #1;
        wait_done();
        chk(8'(fail), 8'h01, "abort on busy");
        repeat (30) @(posedge ref_clk);
        #1;
        chk(8'(serial_mode), 8'h00, "mode during rf");
        @(posedge ref_clk);
        rf_active <= 1'b0;
        #1;
        wait_ready();
        chk(8'(serial_mode), 8'h01, "mode after rf");
        xfer(1'b0, 16'h0000, 8'h00);
        chk(rdata, 8'h3c, "aborted write dropped");
        $display("test busy done");
        conclude();
    end
endmodule
